// ==== shared/hold_arb_defines.svh ====
// constants for the external bus hold arbiter
`ifndef HOLD_ARB_DEFINES_SVH
`define HOLD_ARB_DEFINES_SVH

// =====================================================================
// synchroniser
`define HOLD_SYNC_STAGES 2
`define HOLD_SYNC_RESET_LEVEL 1'h1

// =====================================================================
// reset values
`define HOLD_ACK_N_RESET 1'h1
`define HOLD_FLOAT_RESET 1'h0
`define HOLD_PULLUP_RESET 1'h1

`endif

// ==== shared/hold_arb_pkg.sv ====
// types for the external bus hold arbiter
package hold_arb_pkg;

    // =================================================================
    // arbitration states
    typedef enum logic [2:0] {
        st_idle,
        st_drain,
        st_float,
        st_ack,
        st_resume
    } hold_state_t;

    // =================================================================
    // carriers
    typedef struct packed {
        logic busy;
        logic pending;
    } mem_status_t;

    typedef struct packed {
        logic pin14_alt_sel;
        logic pin15_alt_sel;
        logic pin15_dir_out;
        logic hold_disable;
        logic trip_enable;
        logic pin14_pullup_dis;
        logic pin15_pullup_dis;
    } pin_config_t;

    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_t;

    typedef struct packed {
        hold_state_t state;
        logic ack_n;
        logic bus_float;
        logic pu14;
        logic pu15;
        logic pu_armed;
    } arb_state_t;

endpackage : hold_arb_pkg

// ==== core/hold_sync.sv ====
// multi-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "hold_arb_defines.svh"

module hold_sync #(
    parameter int WIDTH = 2,
    parameter int STAGES = `HOLD_SYNC_STAGES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);

    // =================================================================
    // parameter check
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
        $error("hold_sync: need at least two stages and one bit");
    end

    // =================================================================
    // stages
    logic [STAGES*WIDTH-1:0] chain_q;
    logic [STAGES*WIDTH-1:0] chain_d;

    always_comb begin
        chain_d = {chain_q[(STAGES-1)*WIDTH-1:0], raw};
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chain_q <= {(STAGES*WIDTH){`HOLD_SYNC_RESET_LEVEL}};
        end else begin
            chain_q <= chain_d;
        end
    end

    assign synced = chain_q[STAGES*WIDTH-1 -: WIDTH];

endmodule : hold_sync

`default_nettype wire

// ==== core/external_bus_hold_arbiter.sv ====
// hold request arbitration and shared pin steering for the memory interface
`timescale 1ns/100ps
`default_nettype none
`include "hold_arb_defines.svh"

module external_bus_hold_arbiter #(
    parameter int SYNC_STAGES = `HOLD_SYNC_STAGES
) (
    input wire logic mclk,
    input wire logic rstn,
    input var hold_arb_pkg::pin_config_t cfg,
    input var hold_arb_pkg::mem_status_t mem,
    input wire logic shared_pin_fourteen,
    input wire logic shared_pin_fifteen,
    input wire logic pin15_data,
    output var hold_arb_pkg::pin_drive_t shared_pin_fifteen_drv,
    output logic ext_hold_ack_n,
    output logic bus_float,
    output logic access_stall,
    output logic trip_zone_three_n,
    output logic trip_zone_four_n,
    output logic pin14_pullup_en,
    output logic pin15_pullup_en
);

    // =================================================================
    // parameter check
    if (SYNC_STAGES < 2) begin : g_bad_stages
        $error("external_bus_hold_arbiter: SYNC_STAGES below two");
    end

    // =================================================================
    // input synchronisation
    logic [1:0] pins_sync;
    logic pin14_s;
    logic pin15_s;
    logic ext_hold_req_n;
    logic hold_req;
    logic mem_idle;

    hold_sync #(
        .WIDTH(2),
        .STAGES(SYNC_STAGES)
    ) i_hold_sync (
        .mclk(mclk),
        .rstn(rstn),
        .raw({shared_pin_fourteen, shared_pin_fifteen}),
        .synced(pins_sync)
    );

    assign pin14_s = pins_sync[1];
    assign pin15_s = pins_sync[0];
    assign ext_hold_req_n = pin14_s;
    // the hold function sees the pin whatever its trip role
    assign hold_req = cfg.pin14_alt_sel && !cfg.hold_disable && !ext_hold_req_n;
    assign mem_idle = !mem.busy && !mem.pending;

    // =================================================================
    // state
    hold_arb_pkg::arb_state_t s_q;
    hold_arb_pkg::arb_state_t s_d;

    always_comb begin
        s_d = s_q;
        // pullups stay on through reset, software may drop them later
        s_d.pu_armed = 1'h1;
        if (s_q.pu_armed) begin
            s_d.pu14 = !cfg.pin14_pullup_dis;
            s_d.pu15 = !cfg.pin15_pullup_dis;
        end
        unique case (s_q.state)
            hold_arb_pkg::st_idle: begin
                if (hold_req) begin
                    s_d.state = hold_arb_pkg::st_drain;
                end
            end
            hold_arb_pkg::st_drain: begin
                if (!hold_req) begin
                    s_d.state = hold_arb_pkg::st_idle;
                end else if (mem_idle) begin
                    s_d.state = hold_arb_pkg::st_float;
                    s_d.bus_float = 1'h1;
                end
            end
            hold_arb_pkg::st_float: begin
                s_d.state = hold_arb_pkg::st_ack;
                s_d.ack_n = 1'h0;
            end
            hold_arb_pkg::st_ack: begin
                if (ext_hold_req_n || !cfg.pin14_alt_sel || cfg.hold_disable) begin
                    s_d.state = hold_arb_pkg::st_resume;
                    s_d.ack_n = 1'h1;
                end
            end
            hold_arb_pkg::st_resume: begin
                s_d.state = hold_arb_pkg::st_idle;
                s_d.bus_float = 1'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q.state <= hold_arb_pkg::st_idle;
            s_q.ack_n <= `HOLD_ACK_N_RESET;
            s_q.bus_float <= `HOLD_FLOAT_RESET;
            s_q.pu14 <= `HOLD_PULLUP_RESET;
            s_q.pu15 <= `HOLD_PULLUP_RESET;
            s_q.pu_armed <= 1'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // =================================================================
    // outputs
    logic ack_role;
    logic trip4_role;

    assign ack_role = cfg.pin15_alt_sel && cfg.pin15_dir_out;
    assign trip4_role = cfg.pin15_alt_sel && !cfg.pin15_dir_out;

    always_comb begin
        shared_pin_fifteen_drv.out = pin15_data;
        shared_pin_fifteen_drv.oe_n = !cfg.pin15_dir_out;
        if (ack_role) begin
            shared_pin_fifteen_drv.out = s_q.ack_n;
        end else if (trip4_role) begin
            shared_pin_fifteen_drv.oe_n = 1'h1;
        end
    end

    assign ext_hold_ack_n = s_q.ack_n;
    assign bus_float = s_q.bus_float;
    // new accesses wait while the bus belongs to the outside master
    assign access_stall = s_q.state != hold_arb_pkg::st_idle
        && s_q.state != hold_arb_pkg::st_drain;
    assign trip_zone_three_n = !(cfg.trip_enable && cfg.pin14_alt_sel && !pin14_s);
    assign trip_zone_four_n = !(cfg.trip_enable && trip4_role && !pin15_s);
    assign pin14_pullup_en = s_q.pu14;
    assign pin15_pullup_en = s_q.pu15;

    // =================================================================
    // checks
    sequence s_drain_done;
        s_q.state == hold_arb_pkg::st_drain && hold_req && mem_idle;
    endsequence

    sequence s_granted;
        ##1 bus_float ##1 !ext_hold_ack_n;
    endsequence

    property p_release_idle;
        @(posedge mclk) disable iff (!rstn)
        $rose(bus_float) |-> $past(mem_idle) && $past(hold_req);
    endproperty
    a_release_idle: assert property (p_release_idle) else $error("bus floated while busy");

    property p_grant_steps;
        @(posedge mclk) disable iff (!rstn)
        s_drain_done |-> s_granted;
    endproperty
    a_grant_steps: assert property (p_grant_steps) else $error("grant sequence broken");

    property p_ack_floated;
        @(posedge mclk) disable iff (!rstn)
        !ext_hold_ack_n |-> bus_float && access_stall;
    endproperty
    a_ack_floated: assert property (p_ack_floated) else $error("ack low with bus driven");

    property p_disable_blocks;
        @(posedge mclk) disable iff (!rstn)
        cfg.hold_disable && s_q.state == hold_arb_pkg::st_idle |=> !bus_float;
    endproperty
    a_disable_blocks: assert property (p_disable_blocks) else $error("hold taken while disabled");

    property p_ack_release;
        @(posedge mclk) disable iff (!rstn)
        !ext_hold_ack_n && ext_hold_req_n |=> ext_hold_ack_n;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held after release");

    property p_resume_drive;
        @(posedge mclk) disable iff (!rstn)
        $rose(ext_hold_ack_n) |=> !bus_float && !access_stall;
    endproperty
    a_resume_drive: assert property (p_resume_drive) else $error("bus not resumed");

    property p_trip_gate;
        @(posedge mclk) disable iff (!rstn)
        !cfg.trip_enable |-> trip_zone_three_n && trip_zone_four_n;
    endproperty
    a_trip_gate: assert property (p_trip_gate) else $error("trip passed while disabled");

    property p_pin_role;
        @(posedge mclk) disable iff (!rstn)
        cfg.pin15_alt_sel |-> shared_pin_fifteen_drv.oe_n == !cfg.pin15_dir_out
            && (!cfg.pin15_dir_out || shared_pin_fifteen_drv.out == ext_hold_ack_n);
    endproperty
    a_pin_role: assert property (p_pin_role) else $error("pin15 role wrong");

    property p_gpio_default;
        @(posedge mclk) disable iff (!rstn)
        !cfg.pin14_alt_sel && s_q.state == hold_arb_pkg::st_idle |=> !bus_float [*2];
    endproperty
    a_gpio_default: assert property (p_gpio_default) else $error("gpio pin caused hold");

    property p_sync_delay;
        @(posedge mclk) disable iff (!rstn)
        s_q.state == hold_arb_pkg::st_idle && $rose(hold_req) |-> !$past(shared_pin_fourteen, 2)
            || $past(cfg.hold_disable) || !$past(cfg.pin14_alt_sel);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("request used unsynchronised");

endmodule : external_bus_hold_arbiter

`default_nettype wire

// ==== tb/hold_master_model.sv ====
// outside bus master model for the hold handshake
`timescale 1ns/100ps
`default_nettype none

module hold_master_model (
    input wire logic want,
    input wire logic ack_n,
    output logic ext_hold_req_n,
    output logic drives_bus
);
    // =================================================================
    // request line and bus ownership
    assign ext_hold_req_n = want ? 1'h0 : 1'h1;
    assign drives_bus = !ack_n && want;
endmodule : hold_master_model

`default_nettype wire

// ==== tb/external_bus_hold_arbiter_test.sv ====
// testbench for the external bus hold arbiter
`timescale 1ns/100ps
`default_nettype none

module external_bus_hold_arbiter_test;
    hold_arb_pkg::pin_config_t cfg;
    hold_arb_pkg::mem_status_t mem;
    hold_arb_pkg::pin_drive_t drv;
    logic mclk, rstn, want, pin15_tb, pin15_data, ack_n, flt, stall;
    logic trip3_n, trip4_n, pu14, pu15, req_n, mbus, pin15;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    // =================================================================
    // clock, pin15 wire, instances
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    assign pin15 = drv.oe_n ? pin15_tb : drv.out;

    external_bus_hold_arbiter i_external_bus_hold_arbiter (
        .mclk(mclk), .rstn(rstn), .cfg(cfg), .mem(mem),
        .shared_pin_fourteen(req_n), .shared_pin_fifteen(pin15),
        .pin15_data(pin15_data), .shared_pin_fifteen_drv(drv), .ext_hold_ack_n(ack_n),
        .bus_float(flt), .access_stall(stall), .trip_zone_three_n(trip3_n),
        .trip_zone_four_n(trip4_n), .pin14_pullup_en(pu14), .pin15_pullup_en(pu15)
    );
    hold_master_model i_hold_master_model (
        .want(want), .ack_n(pin15), .ext_hold_req_n(req_n), .drives_bus(mbus)
    );

    // =================================================================
    // checking and closing
    task chk(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task wait_ack(input logic lvl, output int k);
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (ack_n !== lvl && k < 60);
    endtask : wait_ack

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // =================================================================
    // scenarios
    task t_reset;
        chk("ack_n", 1'h1, ack_n);
        chk("bus_float", 1'h0, flt);
        chk("stall", 1'h0, stall);
        chk("pullup14", 1'h1, pu14);
        chk("pullup15", 1'h1, pu15);
        chk("trip3", 1'h1, trip3_n);
        chk("trip4", 1'h1, trip4_n);
        chk("pin15 gpio", pin15_data, drv.out);
        chk("pin15 gpio oe_n", 1'h0, drv.oe_n);
        $display("test reset done");
    endtask : t_reset

    task t_hold;
        want = 1'h1;
        wait_ack(1'h0, n);
        chk("ack latency", 1'h1, n == 5);
        chk("float", 1'h1, flt);
        chk("stall", 1'h1, stall);
        chk("pin15 oe_n", 1'h0, drv.oe_n);
        chk("master bus", 1'h1, mbus);
        want = 1'h0;
        wait_ack(1'h1, n);
        chk("release latency", 1'h1, n == 3);
        chk("float held", 1'h1, flt);
        @(negedge mclk);
        chk("float off", 1'h0, flt);
        chk("stall off", 1'h0, stall);
        $display("test hold done");
    endtask : t_hold

    task t_busy;
        mem.busy = 1'h1;
        want = 1'h1;
        repeat (8) @(negedge mclk);
        chk("busy ack", 1'h1, ack_n);
        chk("busy float", 1'h0, flt);
        mem = '{busy: 1'h0, pending: 1'h1};
        repeat (4) @(negedge mclk);
        chk("pending float", 1'h0, flt);
        mem.pending = 1'h0;
        wait_ack(1'h0, n);
        chk("drain latency", 1'h1, n == 2);
        want = 1'h0;
        wait_ack(1'h1, n);
        repeat (2) @(negedge mclk);
        $display("test busy done");
    endtask : t_busy

    task t_disable;
        cfg.hold_disable = 1'h1;
        want = 1'h1;
        repeat (10) @(negedge mclk);
        chk("disabled ack", 1'h1, ack_n);
        chk("disabled float", 1'h0, flt);
        cfg.hold_disable = 1'h0;
        cfg.pin14_alt_sel = 1'h0;
        repeat (10) @(negedge mclk);
        chk("gpio pin14 float", 1'h0, flt);
        want = 1'h0;
        repeat (3) @(negedge mclk);
        cfg.pin14_alt_sel = 1'h1;
        repeat (2) @(negedge mclk);
        chk("no stray hold", 1'h0, flt);
        chk("no stray ack", 1'h1, ack_n);
        $display("test disable done");
    endtask : t_disable

    task t_trip;
        want = 1'h1;
        repeat (3) @(negedge mclk);
        chk("trip3 masked", 1'h1, trip3_n);
        cfg.trip_enable = 1'h1;
        @(negedge mclk);
        chk("trip3 live", 1'h0, trip3_n);
        wait_ack(1'h0, n);
        chk("trip float", 1'h1, flt);
        want = 1'h0;
        wait_ack(1'h1, n);
        repeat (2) @(negedge mclk);
        cfg.pin15_dir_out = 1'h0;
        pin15_tb = 1'h0;
        repeat (3) @(negedge mclk);
        chk("trip4", 1'h0, trip4_n);
        chk("pin15 input", 1'h1, drv.oe_n);
        pin15_tb = 1'h1;
        cfg.trip_enable = 1'h0;
        $display("test trip done");
    endtask : t_trip

    task t_pullup;
        cfg.pin14_pullup_dis = 1'h1;
        repeat (2) @(negedge mclk);
        chk("pullup14 off", 1'h0, pu14);
        chk("pullup15 on", 1'h1, pu15);
        $display("test pullup done");
    endtask : t_pullup

    // =================================================================
    // main sequence
    initial begin
        cfg = '0;
        mem = '0;
        want = 1'h0;
        pin15_tb = 1'h1;
        pin15_data = 1'h0;
        rstn = 1'h0;
        repeat (4) @(negedge mclk);
        cfg.pin15_dir_out = 1'h1;
        @(negedge mclk);
        t_reset();
        rstn = 1'h1;
        @(negedge mclk);
        cfg.pin14_alt_sel = 1'h1;
        cfg.pin15_alt_sel = 1'h1;
        t_hold();
        t_busy();
        t_disable();
        t_trip();
        t_pullup();
        give_verdict();
    end
endmodule : external_bus_hold_arbiter_test

`default_nettype wire
